// >>> core/sfe_defines.svh
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH
// Register offsets on the plain register port.
`define SFE_REG_STATUS 8'h00
`define SFE_REG_FUNC 8'h04
`define SFE_REG_ERR 8'h08
`define SFE_REG_MODE 8'h0c
`define SFE_REG_DYN 8'h10
`define SFE_REG_PERS 8'h14
// Status byte fields.
`define SFE_ST_BUSY 0
`define SFE_ST_WEL 1
`define SFE_ST_BP 2
`define SFE_ST_QE 6
`define SFE_ST_STATUS_WRITE_GUARD 7
// Function byte fields.
`define SFE_FR_RSTOFF 0
`define SFE_FR_PPAUSE 2
`define SFE_FR_EPAUSE 3
`define SFE_FR_IRL 4
// Error and mode fields.
`define SFE_ER_WIPE 0
`define SFE_ER_GUARD 1
`define SFE_MD_4B 0
// Reset values.
`define SFE_BP_RST 4'h0
`define SFE_GUARD_RST 16'h0000
// Opcodes.
`define SFE_OP_SECT_A 8'hd7
`define SFE_OP_SECT_B 8'h20
`define SFE_OP_SECT_W 8'h21
`define SFE_OP_B32 8'h52
`define SFE_OP_B32_W 8'h5c
`define SFE_OP_BBIG 8'hd8
`define SFE_OP_BBIG_W 8'hdc
`define SFE_OP_CHIP_A 8'hc7
`define SFE_OP_CHIP_B 8'h60
`define SFE_OP_PROG 8'h02
`define SFE_OP_PROG_W 8'h12
`define SFE_OP_LSET 8'h06
`define SFE_OP_LCLR 8'h04
`define SFE_OP_SFETCH 8'h05
`define SFE_OP_FFETCH 8'h48
`define SFE_OP_SSTORE 8'h01
`define SFE_OP_FSTORE 8'h42
`define SFE_OP_QIN 8'h35
`define SFE_OP_QOUT 8'hf5
`define SFE_OP_PAUSE_A 8'h75
`define SFE_OP_PAUSE_B 8'hb0
`define SFE_OP_CONT_A 8'h7a
`define SFE_OP_CONT_B 8'h30
// Geometry and timing.
`define SFE_SECT_BYTES 32'h0000_1000
`define SFE_B32_BYTES 32'h0000_8000
`define SFE_CLK_NS 5
`define SFE_SUS_LAT_NS 100000
`define SFE_RES_GAP_NS 80000
`endif

// >>> core/sfe_pkg.sv
package sfe_pkg;
  typedef enum logic [2:0] {
    k_none, k_sector, k_blk32, k_blkbig, k_chip, k_prog, k_status_store_cmd
  } sfe_kind_e;
  typedef enum logic [1:0] {st_ready, st_run, st_pause} sfe_state_e;
endpackage : sfe_pkg

// >>> core/sfe_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_timer #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Control.
  input wire logic start,
  input wire logic [W-1:0] load,
  input wire logic hold,
  // State.
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic done_q;
  wire logic tick = (cnt_q != '0) && !hold;

  if (W < 2) begin : g_bad_w
    $error("sfe_timer width too small");
  end

  // A held count keeps its remainder, so a resumed run finishes its time.
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      if (start) begin
        cnt_q <= load;
      end else if (tick) begin
        cnt_q <= cnt_q - 1'b1;
      end
      done_q <= !start && tick && (cnt_q == W'(1));
    end
  end

  assign busy = cnt_q != '0;
  assign done = done_q;
endmodule : sfe_timer
`default_nettype wire

// >>> core/sfe_ctrl.sv
// Summary of operation
// - Erase sets every bit of the addressed unit only; others untouched.
// - Uniform 4 Kbyte sectors; 32/64/256 Kbyte blocks are whole sectors.
// - Sector erase D7h/20h use mode address width; 21h always four bytes.
// - Block erase 52h/D8h use mode width; 5Ch/DCh always four bytes.
// - Chip erase C7h/60h is opcode only and erases all but guarded regions.
// - Self-timed work starts only on select release after a whole command.
// - Busy bit is one while an erase runs, zero when finished.
// - Write latch clears automatically when any erase completes.
// - Chip erase refused with nonzero protect level; both error flags set.
// - Chip erase skips guarded regions without raising error flags.
// - 06h sets the write latch; latch is clear after power-up.
// - Write-type operations need the latch and clear it on completion.
// - 04h clears the write latch, disabling write-type commands.
// - 05h returns status, also while an operation runs.
// - 01h writes protect level, write guard and quad enable, latch needed.
// - 42h sets one-time bits that never return to zero.
// - 35h enters four-bit command mode until F5h or power cycle.
// - Exit is taken only as a two-clock nibble cycle, high nibble first.
// - Pause stops sector, block erase or program, not chip erase.
// - Pause sets program or erase paused flag and clears the latch.
// - After pause, commands are refused until ready; busy shows it.
// - While paused, status writes, same-kind work and its area refused.
// - Continue restarts work and clears the paused flag; gap before pause.
// - While programming runs, only the status read and pause are accepted.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module sfe_ctrl
  import sfe_pkg::*;
#(
  parameter int BIG_BLOCK_KB = 64,
  parameter int GUARD_W = 16,
  parameter int SECT_CYC = 8000,
  parameter int B32_CYC = 16000,
  parameter int BBIG_CYC = 32000,
  parameter int CHIP_CYC = 200000,
  parameter int PROG_CYC = 1000,
  parameter int STATUS_STORE_CMD_CYC = 2000,
  parameter int SUS_CYC = (`SFE_SUS_LAT_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS,
  parameter int GAP_CYC = (`SFE_RES_GAP_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Serial pins.
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Array side.
  output logic wipe_go,
  output logic wipe_all,
  output logic [31:0] wipe_base,
  output logic [31:0] wipe_bytes,
  output logic [GUARD_W-1:0] wipe_skip,
  output logic prog_go,
  output logic [31:0] prog_addr,
  output logic busy_in_progress
);
  if (!(BIG_BLOCK_KB == 64 || BIG_BLOCK_KB == 256) || GUARD_W < 1 ||
      GUARD_W > 16 || SECT_CYC < 1 || B32_CYC < 1 || BBIG_CYC < 1 ||
      CHIP_CYC < 1 || PROG_CYC < 1 || STATUS_STORE_CMD_CYC < 1 || SUS_CYC < 1 ||
      GAP_CYC < 1) begin : g_bad_param
    $error("sfe_ctrl parameter out of range");
  end

  // Bytes a complete command needs, opcode included.
  function automatic logic [3:0] frame_len(input logic [7:0] c,
                                           input logic fb);
    logic [3:0] ab;
    ab = fb ? 4'h4 : 4'h3;
    case (c)
      `SFE_OP_SECT_A, `SFE_OP_SECT_B, `SFE_OP_B32,
      `SFE_OP_BBIG: frame_len = 4'h1 + ab;
      `SFE_OP_SECT_W, `SFE_OP_B32_W, `SFE_OP_BBIG_W: frame_len = 4'h5;
      `SFE_OP_PROG: frame_len = 4'h2 + ab;
      `SFE_OP_PROG_W: frame_len = 4'h6;
      `SFE_OP_SSTORE, `SFE_OP_FSTORE: frame_len = 4'h2;
      `SFE_OP_CHIP_A, `SFE_OP_CHIP_B, `SFE_OP_LSET, `SFE_OP_LCLR,
      `SFE_OP_QIN, `SFE_OP_QOUT, `SFE_OP_PAUSE_A, `SFE_OP_PAUSE_B,
      `SFE_OP_CONT_A, `SFE_OP_CONT_B: frame_len = 4'h1;
      default: frame_len = 4'h0;
    endcase
  endfunction : frame_len

  function automatic sfe_kind_e kind_of(input logic [7:0] c);
    case (c)
      `SFE_OP_SECT_A, `SFE_OP_SECT_B, `SFE_OP_SECT_W: kind_of = k_sector;
      `SFE_OP_B32, `SFE_OP_B32_W: kind_of = k_blk32;
      `SFE_OP_BBIG, `SFE_OP_BBIG_W: kind_of = k_blkbig;
      `SFE_OP_CHIP_A, `SFE_OP_CHIP_B: kind_of = k_chip;
      `SFE_OP_PROG, `SFE_OP_PROG_W: kind_of = k_prog;
      `SFE_OP_SSTORE: kind_of = k_status_store_cmd;
      default: kind_of = k_none;
    endcase
  endfunction : kind_of

  // Erase units are whole sectors, so aligning to the span never splits one.
  function automatic logic [31:0] span_of(input sfe_kind_e k);
    case (k)
      k_sector: span_of = `SFE_SECT_BYTES;
      k_blk32: span_of = `SFE_B32_BYTES;
      default: span_of = 32'(BIG_BLOCK_KB) << 10;
    endcase
  endfunction : span_of

  function automatic logic [31:0] cyc_of(input sfe_kind_e k);
    case (k)
      k_sector: cyc_of = 32'(SECT_CYC);
      k_blk32: cyc_of = 32'(B32_CYC);
      k_blkbig: cyc_of = 32'(BBIG_CYC);
      k_chip: cyc_of = 32'(CHIP_CYC);
      k_prog: cyc_of = 32'(PROG_CYC);
      default: cyc_of = 32'(STATUS_STORE_CMD_CYC);
    endcase
  endfunction : cyc_of

  sfe_state_e st_q;
  sfe_kind_e kind_q;
  logic [7:0] cmd_q, dat_q;
  logic [3:0] cnt_q, bp_q, irl_q;
  logic [31:0] addr_q, rdata_q, wipe_base_q, wipe_bytes_q, prog_addr_q;
  logic [GUARD_W-1:0] dyn_q, pers_q, wipe_skip_q;
  logic [1:0] err_q;
  logic wel_q, qe_q, status_write_guard_q, quad_q, fourb_q, rstoff_q, pp_q, ep_q;
  logic wipe_go_q, wipe_all_q, prog_go_q;
  logic [7:0] status, func;
  logic rx_valid, frame_start, frame_end, frame_whole, tx_en;
  logic [7:0] rx_byte, tx_byte;
  logic op_busy, op_done, sus_busy, gap_busy;

  sfe_link u_link (
    .clock(clock),
    .reset(reset),
    .cs_n_pin(chip_select_n),
    .sck_pin(serial_clock),
    .io_pin(io_in),
    .io_out(io_out),
    .io_oe(io_oe),
    .quad(quad_q),
    .tx_en(tx_en),
    .tx_byte(tx_byte),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .frame_whole(frame_whole)
  );

  // Command decode from the bytes of the frame just closed.
  wire sfe_kind_e cmd_kind = kind_of(cmd_q);
  wire logic [3:0] need = frame_len(cmd_q, fourb_q);
  wire logic open_len = (cmd_q == `SFE_OP_SSTORE) || (cmd_kind == k_prog);
  wire logic len_ok = (need != 4'h0) &&
                      (open_len ? (cnt_q >= need) : (cnt_q == need));
  wire logic running = st_q == st_run;
  wire logic ready = st_q == st_ready;
  // Pause settling blocks everything, the status and function reads excepted.
  wire logic go = frame_end && frame_whole && len_ok && !sus_busy;
  wire logic is_erase = (cmd_kind == k_sector) || (cmd_kind == k_blk32) ||
                        (cmd_kind == k_blkbig) || (cmd_kind == k_chip);
  wire logic bp_set = bp_q != 4'h0;
  wire logic e_lset = go && (cmd_q == `SFE_OP_LSET) && !running;
  wire logic e_lclr = go && (cmd_q == `SFE_OP_LCLR) && !running;
  wire logic e_wipe = go && is_erase && wel_q && ready &&
                      !((cmd_kind == k_chip) && bp_set);
  wire logic e_reject = go && (cmd_kind == k_chip) && wel_q && ready &&
                        bp_set;
  wire logic e_prog = go && (cmd_kind == k_prog) && wel_q && ready;
  wire logic e_status_store_cmd = go && (cmd_kind == k_status_store_cmd) && wel_q && ready;
  wire logic e_function_store_cmd = go && (cmd_q == `SFE_OP_FSTORE) && wel_q && ready;
  wire logic e_qin = go && (cmd_q == `SFE_OP_QIN) && !quad_q && !running;
  wire logic e_qout = go && (cmd_q == `SFE_OP_QOUT) && quad_q &&
                      !running;
  wire logic e_pause = go && ((cmd_q == `SFE_OP_PAUSE_A) ||
                       (cmd_q == `SFE_OP_PAUSE_B)) && running &&
                       (kind_q != k_chip) && (kind_q != k_status_store_cmd) &&
                       !gap_busy && !op_done;
  wire logic e_resume = go && ((cmd_q == `SFE_OP_CONT_A) ||
                        (cmd_q == `SFE_OP_CONT_B)) && (st_q == st_pause);
  wire logic op_start = e_wipe || e_prog || e_status_store_cmd;
  assign tx_en = (cnt_q != 4'h0) && ((cmd_q == `SFE_OP_SFETCH) ||
                 ((cmd_q == `SFE_OP_FFETCH) && !running));
  assign tx_byte = (cmd_q == `SFE_OP_FFETCH) ? func : status;
  wire logic [31:0] span = span_of(cmd_kind);
  wire logic reg_clr = reg_wr && (reg_addr == `SFE_REG_ERR);

  sfe_timer u_op (
    .clock(clock),
    .reset(reset),
    .start(op_start),
    .load(cyc_of(cmd_kind)),
    .hold(st_q == st_pause),
    .busy(op_busy),
    .done(op_done)
  );
  sfe_timer u_sus (
    .clock(clock),
    .reset(reset),
    .start(e_pause),
    .load(32'(SUS_CYC)),
    .hold(1'b0),
    .busy(sus_busy),
    .done()
  );
  sfe_timer u_gap (
    .clock(clock),
    .reset(reset),
    .start(e_resume),
    .load(32'(GAP_CYC)),
    .hold(1'b0),
    .busy(gap_busy),
    .done()
  );

  always_comb begin
    status = 8'h00;
    status[`SFE_ST_BUSY] = busy_in_progress;
    status[`SFE_ST_WEL] = wel_q;
    status[`SFE_ST_BP+:4] = bp_q;
    status[`SFE_ST_QE] = qe_q;
    status[`SFE_ST_STATUS_WRITE_GUARD] = status_write_guard_q;
    func = 8'h00;
    func[`SFE_FR_RSTOFF] = rstoff_q;
    func[`SFE_FR_PPAUSE] = pp_q;
    func[`SFE_FR_EPAUSE] = ep_q;
    func[`SFE_FR_IRL+:4] = irl_q;
  end

  // Frame byte capture.
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= 4'h0;
      cmd_q <= 8'h00;
      dat_q <= 8'h00;
      addr_q <= 32'h0;
    end else if (frame_start) begin
      cnt_q <= 4'h0;
      addr_q <= 32'h0;
    end else if (rx_valid) begin
      cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      if (cnt_q == 4'h0) begin
        cmd_q <= rx_byte;
      end
      if (cnt_q == 4'h1) begin
        dat_q <= rx_byte;
      end
      if (cnt_q != 4'h0 && cnt_q < need && !open_len) begin
        addr_q <= {addr_q[23:0], rx_byte};
      end else if (cnt_q != 4'h0 && cnt_q < need - 4'h1) begin
        addr_q <= {addr_q[23:0], rx_byte};
      end
    end
  end

  // Operation state and the latch.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= st_ready;
      kind_q <= k_none;
      wel_q <= 1'b0;
      pp_q <= 1'b0;
      ep_q <= 1'b0;
    end else begin
      case (st_q)
        st_ready: begin
          if (op_start) begin
            st_q <= st_run;
            kind_q <= cmd_kind;
          end
        end
        st_run: begin
          if (op_done) begin
            st_q <= st_ready;
            kind_q <= k_none;
          end else if (e_pause) begin
            st_q <= st_pause;
            pp_q <= kind_q == k_prog;
            ep_q <= kind_q != k_prog;
          end
        end
        default: begin
          if (e_resume) begin
            st_q <= st_run;
            pp_q <= 1'b0;
            ep_q <= 1'b0;
          end
        end
      endcase
      if (e_lset) begin
        wel_q <= 1'b1;
      end else if (e_lclr || op_done || e_pause || e_function_store_cmd) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Status, function, mode and guard bits.
  always_ff @(posedge clock) begin
    if (reset) begin
      bp_q <= `SFE_BP_RST;
      qe_q <= 1'b0;
      status_write_guard_q <= 1'b0;
      quad_q <= 1'b0;
      rstoff_q <= 1'b0;
      irl_q <= 4'h0;
      err_q <= 2'b00;
      fourb_q <= 1'b0;
      dyn_q <= GUARD_W'(`SFE_GUARD_RST);
      pers_q <= GUARD_W'(`SFE_GUARD_RST);
    end else begin
      if (e_status_store_cmd) begin
        bp_q <= dat_q[`SFE_ST_BP+:4];
        qe_q <= dat_q[`SFE_ST_QE];
        status_write_guard_q <= dat_q[`SFE_ST_STATUS_WRITE_GUARD];
      end
      if (e_function_store_cmd) begin
        rstoff_q <= rstoff_q | dat_q[`SFE_FR_RSTOFF];
        irl_q <= irl_q | dat_q[`SFE_FR_IRL+:4];
      end
      if (e_qin) begin
        quad_q <= 1'b1;
      end else if (e_qout) begin
        quad_q <= 1'b0;
      end
      // A refusal in the clearing cycle still leaves its flags set.
      err_q <= (err_q & ~(reg_clr ? reg_wdata[1:0] : 2'b00)) |
               {2{e_reject}};
      if (reg_wr && reg_addr == `SFE_REG_MODE) begin
        fourb_q <= reg_wdata[`SFE_MD_4B];
      end
      if (reg_wr && reg_addr == `SFE_REG_DYN) begin
        dyn_q <= reg_wdata[GUARD_W-1:0];
      end
      if (reg_wr && reg_addr == `SFE_REG_PERS) begin
        pers_q <= reg_wdata[GUARD_W-1:0];
      end
    end
  end

  // Array requests, registered one cycle after acceptance.
  always_ff @(posedge clock) begin
    if (reset) begin
      wipe_go_q <= 1'b0;
      wipe_all_q <= 1'b0;
      wipe_base_q <= 32'h0;
      wipe_bytes_q <= 32'h0;
      wipe_skip_q <= '0;
      prog_go_q <= 1'b0;
      prog_addr_q <= 32'h0;
    end else begin
      wipe_go_q <= e_wipe;
      prog_go_q <= e_prog;
      if (e_wipe) begin
        wipe_all_q <= cmd_kind == k_chip;
        wipe_base_q <= (cmd_kind == k_chip) ? 32'h0 :
                       (addr_q & ~(span - 32'h1));
        wipe_bytes_q <= (cmd_kind == k_chip) ? 32'h0 : span;
        wipe_skip_q <= (cmd_kind == k_chip) ? (dyn_q | pers_q) : '0;
      end
      if (e_prog) begin
        prog_addr_q <= addr_q;
      end
    end
  end

  wire logic [31:0] rsel = (reg_addr == `SFE_REG_STATUS) ? 32'(status) :
                           (reg_addr == `SFE_REG_FUNC) ? 32'(func) :
                           (reg_addr == `SFE_REG_ERR) ? 32'(err_q) :
                           (reg_addr == `SFE_REG_MODE) ? 32'(fourb_q) :
                           (reg_addr == `SFE_REG_DYN) ? 32'(dyn_q) :
                           (reg_addr == `SFE_REG_PERS) ? 32'(pers_q) :
                           32'h0;
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rsel : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign wipe_go = wipe_go_q;
  assign wipe_all = wipe_all_q;
  assign wipe_base = wipe_base_q;
  assign wipe_bytes = wipe_bytes_q;
  assign wipe_skip = wipe_skip_q;
  assign prog_go = prog_go_q;
  assign prog_addr = prog_addr_q;
  assign busy_in_progress = running || sus_busy;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_latch_done_clear: assert property (op_done |=> !wel_q)
    else $error("latch not cleared at completion");
  chk_busy_while_run: assert property (
    $rose(running) |-> busy_in_progress [*8])
    else $error("busy low during operation");
  chk_latch_set: assert property (e_lset |=> wel_q && status[1])
    else $error("latch set command lost");
  chk_latch_clear: assert property (e_lclr |=> !wel_q)
    else $error("latch clear command lost");
  chk_chip_reject: assert property (
    e_reject |=> (err_q == 2'b11) && !running && !wipe_go)
    else $error("protected chip erase not refused");
  chk_chip_no_err: assert property (
    (e_wipe && cmd_kind == k_chip) |=>
    ((err_q & ~$past(err_q)) == 2'b00) && wipe_all)
    else $error("guarded chip erase raised error");
  chk_pause_flags: assert property (
    e_pause |=> (pp_q ^ ep_q) && !wel_q && busy_in_progress)
    else $error("pause flags wrong");
  chk_no_chip_pause: assert property (
    (go && running && (kind_q == k_chip) && !op_done &&
     ((cmd_q == `SFE_OP_PAUSE_A) || (cmd_q == `SFE_OP_PAUSE_B))) |=>
    running && !ep_q && !pp_q)
    else $error("chip erase paused");
  chk_otp_sticky: assert property (
    (($past(irl_q) & ~irl_q) == 4'h0) && !($past(rstoff_q) && !rstoff_q))
    else $error("one-time bit cleared");
  chk_wipe_latched: assert property (
    e_wipe |-> wel_q && frame_end ##1 wipe_go)
    else $error("erase without latch or frame end");
  chk_resume_clears: assert property (
    e_resume |=> !pp_q && !ep_q && running)
    else $error("resume flags not cleared");
endmodule : sfe_ctrl
`default_nettype wire

// >>> core/sfe_link.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_link (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Pins.
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic [3:0] io_pin,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Core side.
  input wire logic quad,
  input wire logic tx_en,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic frame_start,
  output logic frame_end,
  output logic frame_whole
);
  logic [5:0] s1_q, s2_q;
  logic [1:0] hist_q;
  logic [7:0] sr_q, tx_q, byte_q;
  logic [2:0] bit_q;
  logic valid_q, load_q;
  logic [3:0] out_q, oe_q;

  // Select, clock and data pass the same two stages, so data is settled
  // when the sampled clock edge is seen.
  wire logic cs_n = s2_q[5];
  wire logic sck = s2_q[4];
  wire logic rise = sck && !hist_q[0] && !cs_n;
  wire logic fall = !sck && hist_q[0] && !cs_n;
  wire logic [2:0] step = quad ? 3'h4 : 3'h1;
  wire logic [7:0] sr_d = quad ? {sr_q[3:0], s2_q[3:0]} :
                                 {sr_q[6:0], s2_q[0]};

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= 6'h20;
      s2_q <= 6'h20;
      hist_q <= 2'b10;
    end else begin
      s1_q <= {cs_n_pin, sck_pin, io_pin};
      s2_q <= s1_q;
      hist_q <= s2_q[5:4];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bit_q <= 3'h0;
      sr_q <= 8'h00;
      byte_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      valid_q <= rise && (bit_q + step == 3'h0);
      if (frame_start) begin
        bit_q <= 3'h0;
      end else if (rise) begin
        bit_q <= bit_q + step;
        sr_q <= sr_d;
        if (bit_q + step == 3'h0) begin
          byte_q <= sr_d;
        end
      end
    end
  end

  // Reply bits change on the falling edge, high bit or nibble first.
  always_ff @(posedge clock) begin
    if (reset) begin
      load_q <= 1'b0;
      tx_q <= 8'h00;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      load_q <= valid_q;
      if (load_q) begin
        tx_q <= tx_byte;
      end else if (fall && tx_en) begin
        tx_q <= quad ? {tx_q[3:0], 4'h0} : {tx_q[6:0], 1'b0};
      end
      if (cs_n) begin
        oe_q <= 4'h0;
      end else if (fall && tx_en) begin
        out_q <= quad ? tx_q[7:4] : {2'b00, tx_q[7], 1'b0};
        oe_q <= quad ? 4'hf : 4'h2;
      end
    end
  end

  assign rx_valid = valid_q;
  assign rx_byte = byte_q;
  assign frame_start = !cs_n && hist_q[1];
  assign frame_end = cs_n && !hist_q[1];
  assign frame_whole = bit_q == 3'h0;
  assign io_out = out_q;
  assign io_oe = oe_q;
endmodule : sfe_link
`default_nettype wire

// >>> bench/sfe_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_host (
  // Serial pins.
  output logic cs_n,
  output logic sck,
  output logic [3:0] io,
  // Reply line.
  input wire logic miso
);
  // Reply bits are taken on the rising edge, as a mode 0 host does.
  logic [7:0] rx;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'h5;
  end
  // Mode 0 frame of nb bits, MSB first; the clock idles low outside it.
  task automatic frame(input logic [47:0] d, input int nb);
    cs_n <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      #40 io[0] <= d[i];
      #40 sck <= 1'b1;
      rx <= {rx[6:0], miso};
      #80 sck <= 1'b0;
    end
    #80 cs_n <= 1'b1;
    // A released line must not keep showing the last bit.
    io <= ~io;
    #800;
  endtask : frame
  // Four-bit frame of nn nibbles, high nibble first.
  task automatic qframe(input logic [15:0] d, input int nn);
    cs_n <= 1'b0;
    for (int i = nn - 1; i >= 0; i--) begin
      #40 io <= d[4*i+:4];
      #40 sck <= 1'b1;
      #80 sck <= 1'b0;
    end
    #80 cs_n <= 1'b1;
    io <= ~io;
    #800;
  endtask : qframe
endmodule : sfe_host
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module testbench;
  logic clock, reset, cs_n, sck, reg_wr, reg_rd, wipe_go, busy;
  logic wipe_all, prog_go;
  logic [3:0] io, dout, oe;
  logic [15:0] skip;
  logic [31:0] prog_addr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, wipe_base, wipe_bytes, base_q, len_q;
  int err_count, total_checks, go_n, n;
  typedef struct {
    logic [47:0] d; int nb; logic [7:0] st; bit e; logic [31:0] base, span;
  } sfe_row_s;
  // Erase and program rows give base and span; chip erase and program
  // report a span of zero.
  sfe_row_s rows [17] = '{
    '{48'h06, 8, 8'h02, 0, 0, 0}, '{48'h04, 8, 8'h00, 0, 0, 0},
    '{48'h20001234, 32, 8'h00, 0, 0, 0}, '{48'h06, 7, 8'h00, 0, 0, 0},
    '{48'h06, 8, 8'h02, 0, 0, 0},
    '{48'hd7001234, 32, 8'h03, 1, 32'h1000, 32'h1000},
    '{48'h06, 8, 8'h02, 0, 0, 0},
    '{48'h2100005678, 40, 8'h03, 1, 32'h5000, 32'h1000},
    '{48'h06, 8, 8'h02, 0, 0, 0},
    '{48'h52009abc, 32, 8'h03, 1, 32'h8000, 32'h8000},
    '{48'h06, 8, 8'h02, 0, 0, 0},
    '{48'hdc00012345, 40, 8'h03, 1, 32'h10000, 32'h10000},
    '{48'h06, 8, 8'h02, 0, 0, 0}, '{48'h60, 8, 8'h03, 1, 0, 0},
    '{48'h06, 8, 8'h02, 0, 0, 0},
    '{48'h02001234aa, 40, 8'h00, 1, 32'h1234, 0},
    '{48'h04, 8, 8'h00, 0, 0, 0}};
  sfe_host host (.cs_n(cs_n), .sck(sck), .io(io), .miso(dout[1]));
  sfe_ctrl #(.SECT_CYC(2000), .B32_CYC(2100), .BBIG_CYC(2200),
    .CHIP_CYC(2300), .PROG_CYC(50), .STATUS_STORE_CMD_CYC(50), .SUS_CYC(40),
    .GAP_CYC(30)) dut (.clock(clock), .reset(reset),
    .chip_select_n(cs_n), .serial_clock(sck), .io_in(io), .io_out(dout),
    .io_oe(oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wipe_go(wipe_go),
    .wipe_all(wipe_all), .wipe_base(wipe_base), .wipe_bytes(wipe_bytes),
    .wipe_skip(skip), .prog_go(prog_go), .prog_addr(prog_addr),
    .busy_in_progress(busy));
  always @(posedge clock) if (wipe_go === 1'b1) begin
    go_n <= go_n + 1;
    base_q <= wipe_base;
    len_q <= wipe_bytes;
  end else if (prog_go === 1'b1) begin
    go_n <= go_n + 1;
    base_q <= prog_addr;
    len_q <= 0;
  end
  task automatic chk(input string s, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Polls busy under a bound, as a host would before its next command.
  task automatic idle;
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clock);
    chk("busy", {31'h0, busy}, 0);
  endtask : idle
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(`SFE_REG_STATUS, 0);
    repeat (4) @(posedge clock);
    foreach (rows[i]) begin
      n = go_n;
      host.frame(rows[i].d, rows[i].nb);
      rd(`SFE_REG_STATUS, rows[i].st);
      if (rows[i].e) begin
        chk("go", go_n - n, 1);
        chk("base", base_q, rows[i].base);
        chk("span", len_q, rows[i].span);
        idle();
        rd(`SFE_REG_STATUS, 0);
      end
    end
    host.frame(48'h06, 8);
    host.frame(48'h0104, 16);
    idle();
    rd(`SFE_REG_STATUS, 8'h04);
    host.frame(48'h0500, 16);
    chk("reply", host.rx, 8'h04);
    chk("oe", oe, 0);
    host.frame(48'h06, 8);
    n = go_n;
    host.frame(48'hc7, 8);
    chk("go", go_n - n, 0);
    rd(`SFE_REG_ERR, 3);
    wr(`SFE_REG_ERR, 3);
    rd(`SFE_REG_ERR, 0);
    host.frame(48'h06, 8);
    host.frame(48'h0100, 16);
    idle();
    wr(`SFE_REG_DYN, 32'h00f0);
    wr(`SFE_REG_PERS, 32'h0300);
    host.frame(48'h06, 8);
    host.frame(48'hc7, 8);
    chk("skip", skip, 32'h03f0);
    chk("all", wipe_all, 1);
    idle();
    rd(`SFE_REG_ERR, 0);
    host.frame(48'h06, 8);
    host.frame(48'h20001234, 32);
    host.frame(48'h0500, 16);
    chk("reply", host.rx, 8'h03);
    host.frame(48'h75, 8);
    rd(`SFE_REG_FUNC, 8'h08);
    rd(`SFE_REG_STATUS, 0);
    host.frame(48'h30, 8);
    rd(`SFE_REG_FUNC, 0);
    idle();
    host.frame(48'h35, 8);
    host.qframe(16'h06, 2);
    rd(`SFE_REG_STATUS, 8'h02);
    host.qframe(16'hf5, 2);
    host.frame(48'h04, 8);
    rd(`SFE_REG_STATUS, 0);
    rd(8'h20, 0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
